// File: bench/slx_exec_properties.sv
// Concurrent checks on the ports of the execution block.
`timescale 1ns/1ps
`default_nettype none
module slx_exec_properties (
	// Clock and reset.
	input wire logic mclk,
	input wire logic resetn,
	// Instruction port and core state.
	input wire logic ins_valid,
	input wire slx_pkg::slx_instr_s ins,
	input wire logic ins_ready,
	input wire logic done,
	input wire logic discarded,
	input wire logic skip_next,
	input wire logic rf_we,
	input wire logic pm_rd,
	input wire logic [7:0] working_register,
	input wire logic zero_flag,
	// Read channel handshakes.
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	// An accepted instruction that really executes.
	wire logic take = ins_valid && ins_ready && !skip_next;
	// Lookups need one extra cycle for the program memory.
	wire logic look = ins.op inside {slx_pkg::OP_LOOKUP_TO_REGISTER, slx_pkg::OP_LOOKUP_TO_WORKING};
	// The eight skip-capable operations sit in one code range.
	wire logic skop = ins.op >= slx_pkg::OP_SKIP_IF_BIT_CLEAR && ins.op <= slx_pkg::OP_DEC_IN_PLACE_SKIP_IF_NULL;
	a_discard_one_cycle: assert property (ins_valid && ins_ready && skip_next
		|=> done && discarded && ins_ready && !skip_next && !rf_we) else $error("discard slot wrong");
	a_exec_latency: assert property (take && !look |=> !ins_ready && !done ##1 done)
		else $error("execute latency wrong");
	a_lookup_latency: assert property (take && look |=> !done ##1 pm_rd && !done ##1 done)
		else $error("lookup latency wrong");
	a_skip_keeps_zero: assert property (take && skop |=> ##1 $stable(zero_flag))
		else $error("skip changed zero flag");
	a_xor_zero_flag: assert property (take && ins.op == slx_pkg::OP_EXCLUSIVE_OR_IMMEDIATE
		|=> ##1 zero_flag == (working_register == 8'h00)) else $error("zero flag wrong");
	a_write_with_done: assert property (rf_we |-> done && !discarded)
		else $error("register write outside completion");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
endmodule // slx_exec_properties
`default_nettype wire

// File: bench/slx_exec_test.sv
// Self-checking testbench for the execution block.
`timescale 1ns/1ps
`default_nettype none
`include "slx_defs.svh"
module slx_exec_test;
	localparam logic [1:0] OK = `SLX_RESP_OKAY;
	localparam logic [1:0] SE = `SLX_RESP_SLVERR;
	// Stimulus; prot, strobe, ce and bready stay constant.
	logic mclk = 1'b0, resetn = 1'b0, ce = 1'b1, ins_valid = 1'b0, s_axi_bready = 1'b1;
	slx_pkg::slx_instr_s ins = 27'h0000000;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	// Observed outputs.
	logic ins_ready, done, discarded, skip_next, rf_we, pm_rd, zero_flag;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [7:0] rf_addr, rf_wdata, rf_rdata, working_register, lookup_result_high;
	logic [15:0] pm_addr, pm_rdata;
	logic [7:0] rf [256];
	int err_count = 0, cmp_count = 0, cyc = 0;
	// Register file and program memory models; the word is a scramble of its address.
	assign rf_rdata = rf[rf_addr];
	assign pm_rdata = pm_addr ^ 16'hA5C3;
	always @(posedge mclk) if (rf_we) rf[rf_addr] <= rf_wdata;
	slx_exec uut (.mclk, .resetn, .ce, .ins_valid, .ins, .ins_ready, .done, .discarded, .skip_next,
		.rf_addr, .rf_rdata, .rf_we, .rf_wdata, .pm_addr, .pm_rd, .pm_rdata, .working_register,
		.zero_flag, .lookup_result_high, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	// Clock at 100 ns, plus a cycle ceiling so a hang still ends in a verdict.
	initial forever #50 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_count++;
			print_verdict;
		end
	end
	task print_verdict;
		$display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("ERROR at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// Bus write; address and data are released as each is taken.
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
			if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
			if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 50);
		chk(s_axi_bresp, er);
	endtask
	// Bus read; rready comes late on purpose so the slave must hold its answer.
	task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
			if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 50);
		s_axi_rready <= 1'b1;
		@(posedge mclk);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, e);
		chk(s_axi_rresp, er);
	endtask
	// Issue one instruction and wait for its completion; the final step lets writes land.
	task ex(input slx_pkg::slx_op_e op, input logic [7:0] a, input logic [2:0] b,
		input logic [7:0] im, output logic dsc);
		int n;
		ins_valid <= 1'b1;
		ins <= {op, a, b, im};
		n = 0;
		do begin @(posedge mclk); n++; end while (ins_ready !== 1'b1 && n < 50);
		ins_valid <= 1'b0;
		do begin @(posedge mclk); n++; end while (done !== 1'b1 && n < 50);
		chk(done, 1'b1);
		dsc = discarded;
		#1;
	endtask
	// After a skip the next instruction must vanish without touching the register file.
	task tail(input logic s);
		logic [7:0] v;
		logic dsc;
		v = rf[5];
		chk(skip_next, s);
		if (s) begin
			ex(slx_pkg::OP_EXCLUSIVE_OR_IN_PLACE, 8'h05, 3'h0, 8'h00, dsc);
			chk(dsc, 1'b1);
			chk(rf[5], v);
		end
	endtask
	task t_regs;
		rd(`SLX_OFF_CTRL, 32'h1, OK);
		rd(`SLX_OFF_FLAGS, 32'h0, OK);
		wr(`SLX_OFF_WORK, 32'hFFFFFF5A, OK);
		rd(`SLX_OFF_WORK, 32'h5A, OK);
		wr(8'h18, 32'h1, SE);
		rd(8'h18, 32'h0, SE);
		wr(`SLX_OFF_RES_HI, 32'h77, OK);
		rd(`SLX_OFF_RES_HI, 32'h0, OK);
		wr(`SLX_OFF_CTRL, 32'h0, OK);
		repeat (2) @(posedge mclk);
		chk(ins_ready, 1'b0);
		wr(`SLX_OFF_CTRL, 32'h1, OK);
		$display("Test registers finished");
	endtask
	task t_bits;
		logic dsc;
		logic [2:0] b;
		rf[16] = 8'h08;
		for (int i = 0; i < 4; i++) begin
			b = i[0] ? 3'h3 : 3'h2;
			ex(i < 2 ? slx_pkg::OP_SKIP_IF_BIT_CLEAR : slx_pkg::OP_SKIP_IF_BIT_SET, 8'h10, b, 8'h00, dsc);
			tail(i < 2 ? !rf[16][b] : rf[16][b]);
		end
		chk(rf[16], 8'h08);
		$display("Test bit skips finished");
	endtask
	// Move, increment and decrement with their boundary values.
	task t_count;
		logic [7:0] rv [6];
		logic [7:0] r, w;
		logic dsc, z;
		rv = '{8'h00, 8'h5A, 8'hFF, 8'h7F, 8'h01, 8'h00};
		for (int i = 0; i < 6; i++) begin
			rf[32] = rv[i];
			w = working_register;
			z = zero_flag;
			r = (i < 2) ? rv[i] : (i < 4) ? rv[i] + 8'h01 : rv[i] - 8'h01;
			ex(slx_pkg::slx_op_e'(4'h3 + i), 8'h20, 3'h0, 8'h00, dsc);
			chk(i[0] ? rf[32] : working_register, r);
			chk(i[0] ? working_register : rf[32], i[0] ? w : rv[i]);
			chk(zero_flag, z);
			tail(r == 8'h00);
		end
		$display("Test counting skips finished");
	endtask
	task t_look;
		logic dsc;
		logic [15:0] w;
		wr(`SLX_OFF_PTR_HI, 32'h01, OK);
		wr(`SLX_OFF_PTR_LO, 32'h15, OK);
		w = 16'h0115 ^ 16'hA5C3;
		ex(slx_pkg::OP_LOOKUP_TO_REGISTER, 8'h30, 3'h0, 8'h00, dsc);
		chk(pm_addr, 16'h0115);
		chk(rf[48], w[7:0]);
		rd(`SLX_OFF_RES_HI, {24'h0, w[15:8]}, OK);
		wr(`SLX_OFF_PTR_HI, 32'hFF, OK);
		wr(`SLX_OFF_PTR_LO, 32'h00, OK);
		w = 16'hFF00 ^ 16'hA5C3;
		ex(slx_pkg::OP_LOOKUP_TO_WORKING, 8'h31, 3'h0, 8'h00, dsc);
		chk(pm_addr, 16'hFF00);
		chk(working_register, w[7:0]);
		chk(lookup_result_high, w[15:8]);
		$display("Test lookups finished");
	endtask
	task t_xor;
		logic dsc;
		wr(`SLX_OFF_WORK, 32'h0A, OK);
		ex(slx_pkg::OP_EXCLUSIVE_OR_IMMEDIATE, 8'h00, 3'h0, 8'h0F, dsc);
		chk({working_register, zero_flag}, 9'h00A);
		ex(slx_pkg::OP_EXCLUSIVE_OR_IMMEDIATE, 8'h00, 3'h0, 8'h05, dsc);
		rd(`SLX_OFF_FLAGS, 32'h1, OK);
		rf[64] = 8'h0A;
		ex(slx_pkg::OP_EXCLUSIVE_OR_TO_WORKING, 8'h40, 3'h0, 8'h00, dsc);
		chk({working_register, zero_flag}, 9'h014);
		ex(slx_pkg::OP_EXCLUSIVE_OR_IN_PLACE, 8'h40, 3'h0, 8'h00, dsc);
		chk({rf[64], zero_flag}, 9'h001);
		rf[65] = 8'h80;
		ex(slx_pkg::OP_NULL_TEST, 8'h41, 3'h0, 8'h00, dsc);
		chk({rf[65], zero_flag}, 9'h100);
		$display("Test exclusive-or finished");
	endtask
	initial begin
		foreach (rf[i]) rf[i] = 8'h00;
		repeat (4) @(posedge mclk);
		resetn <= 1'b1;
		@(posedge mclk);
		#1;
		t_regs;
		t_bits;
		t_count;
		t_look;
		t_xor;
		print_verdict;
	end
endmodule // slx_exec_test
bind slx_exec slx_exec_properties chk_props (.mclk, .resetn, .ins_valid, .ins, .ins_ready, .done,
	.discarded, .skip_next, .rf_we, .pm_rd, .working_register, .zero_flag, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);
`default_nettype wire

// File: shared/slx_defs.svh
// Constants for the skip, lookup and exclusive-OR execution block.
// Behaviour
// - Bit-clear skip skips when bit is zero
// - Bit-set skip skips when bit is one
// - Move to working, skip if null
// - Move in place, skip if null
// - Increment, store, skip if sum null
// - Decrement, store, skip if result null
// - Lookup: low byte to register, high kept
// - Pointer high upper, pointer low lower bits
// - Lookup low byte to working, two cycles
// - Null test rewrites register, updates zero
// - Immediate XOR into working, updates zero
// - Register XOR into working, updates zero
// - Register XOR in place, updates zero
`ifndef SLX_DEFS_SVH
`define SLX_DEFS_SVH

// Register byte offsets on the bus.
`define SLX_OFF_CTRL 8'h00
`define SLX_OFF_WORK 8'h04
`define SLX_OFF_FLAGS 8'h08
`define SLX_OFF_PTR_LO 8'h0C
`define SLX_OFF_PTR_HI 8'h10
`define SLX_OFF_RES_HI 8'h14

// Field positions.
`define SLX_CTRL_RUN 0
`define SLX_FLAG_ZERO 0
`define SLX_FLAG_SKIP 1
`define SLX_FLAG_BUSY 2

// Reset values.
`define SLX_RST_RUN 1'b1
`define SLX_RST_BYTE 8'h00

// Data widths and arithmetic constants.
`define SLX_BYTE_W 8
`define SLX_ONE 8'h01
`define SLX_NULL 8'h00

// Bus response codes.
`define SLX_RESP_OKAY 2'h0
`define SLX_RESP_SLVERR 2'h2

`endif

// File: shared/slx_pkg.sv
// Types shared by the execution block and its operation unit.
package slx_pkg;

	// Operations that this block executes.
	typedef enum logic [3:0] {
		OP_NOP = 4'h0,
		OP_SKIP_IF_BIT_CLEAR = 4'h1,
		OP_SKIP_IF_BIT_SET = 4'h2,
		OP_MOVE_TO_WORKING_SKIP_IF_NULL = 4'h3,
		OP_MOVE_IN_PLACE_SKIP_IF_NULL = 4'h4,
		OP_INC_TO_WORKING_SKIP_IF_NULL = 4'h5,
		OP_INC_IN_PLACE_SKIP_IF_NULL = 4'h6,
		OP_DEC_TO_WORKING_SKIP_IF_NULL = 4'h7,
		OP_DEC_IN_PLACE_SKIP_IF_NULL = 4'h8,
		OP_LOOKUP_TO_REGISTER = 4'h9,
		OP_LOOKUP_TO_WORKING = 4'hA,
		OP_NULL_TEST = 4'hB,
		OP_EXCLUSIVE_OR_IMMEDIATE = 4'hC,
		OP_EXCLUSIVE_OR_TO_WORKING = 4'hD,
		OP_EXCLUSIVE_OR_IN_PLACE = 4'hE
	} slx_op_e;

	// One decoded instruction.
	typedef struct packed {
		slx_op_e op;
		logic [7:0] reg_addr;
		logic [2:0] bit_sel;
		logic [7:0] imm;
	} slx_instr_s;

	// Result of the operation unit.
	typedef struct packed {
		logic [7:0] res;
		logic wr_reg;
		logic wr_work;
		logic upd_zero;
		logic zero;
		logic skip;
	} slx_alu_s;

	// Sequencer states.
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_EXEC = 2'h1,
		ST_FETCH = 2'h2
	} slx_state_e;

endpackage

// File: verilog/slx_alu.sv
// Combinational operation unit for skip, move, count and XOR operations.
`timescale 1ns/1ps
`default_nettype none
`include "slx_defs.svh"
module slx_alu (
	// Instruction and operands.
	input wire slx_pkg::slx_instr_s instr,
	input wire logic [7:0] operand,
	input wire logic [7:0] work,
	// Result.
	output slx_pkg::slx_alu_s result
);

	// Decode each operation into a result byte and its write targets.
	always_comb begin
		result = '0;
		unique case (instr.op)
			slx_pkg::OP_SKIP_IF_BIT_CLEAR: result.skip = ~operand[instr.bit_sel];
			slx_pkg::OP_SKIP_IF_BIT_SET: result.skip = operand[instr.bit_sel];
			slx_pkg::OP_MOVE_TO_WORKING_SKIP_IF_NULL: begin
				result.res = operand;
				result.wr_work = 1'b1;
			end
			slx_pkg::OP_MOVE_IN_PLACE_SKIP_IF_NULL: begin
				result.res = operand;
				result.wr_reg = 1'b1;
			end
			slx_pkg::OP_INC_TO_WORKING_SKIP_IF_NULL,
			slx_pkg::OP_INC_IN_PLACE_SKIP_IF_NULL: begin
				result.res = operand + `SLX_ONE;
				result.wr_work = (instr.op == slx_pkg::OP_INC_TO_WORKING_SKIP_IF_NULL);
				result.wr_reg = ~result.wr_work;
			end
			slx_pkg::OP_DEC_TO_WORKING_SKIP_IF_NULL,
			slx_pkg::OP_DEC_IN_PLACE_SKIP_IF_NULL: begin
				result.res = operand - `SLX_ONE;
				result.wr_work = (instr.op == slx_pkg::OP_DEC_TO_WORKING_SKIP_IF_NULL);
				result.wr_reg = ~result.wr_work;
			end
			slx_pkg::OP_NULL_TEST: begin
				result.res = operand;
				result.wr_reg = 1'b1;
				result.upd_zero = 1'b1;
			end
			slx_pkg::OP_EXCLUSIVE_OR_IMMEDIATE: begin
				result.res = instr.imm ^ work;
				result.wr_work = 1'b1;
				result.upd_zero = 1'b1;
			end
			slx_pkg::OP_EXCLUSIVE_OR_TO_WORKING: begin
				result.res = operand ^ work;
				result.wr_work = 1'b1;
				result.upd_zero = 1'b1;
			end
			slx_pkg::OP_EXCLUSIVE_OR_IN_PLACE: begin
				result.res = operand ^ work;
				result.wr_reg = 1'b1;
				result.upd_zero = 1'b1;
			end
			// Lookups and no-ops are handled by the sequencer.
			default: result.res = `SLX_NULL;
		endcase
		result.zero = (result.res == `SLX_NULL);
		// The move and count forms skip on a null result.
		if (instr.op inside {slx_pkg::OP_MOVE_TO_WORKING_SKIP_IF_NULL,
				slx_pkg::OP_MOVE_IN_PLACE_SKIP_IF_NULL,
				slx_pkg::OP_INC_TO_WORKING_SKIP_IF_NULL,
				slx_pkg::OP_INC_IN_PLACE_SKIP_IF_NULL,
				slx_pkg::OP_DEC_TO_WORKING_SKIP_IF_NULL,
				slx_pkg::OP_DEC_IN_PLACE_SKIP_IF_NULL}) begin
			result.skip = result.zero;
		end
	end

endmodule // slx_alu
`default_nettype wire

// File: verilog/slx_exec.sv
// Execution block for skip, lookup, null test and XOR instructions.
//
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "slx_defs.svh"
module slx_exec #(
	parameter int PM_W = 16,
	parameter int ADDR_W = 8
) (
	// Clock, reset and clock enable.
	input wire logic mclk,
	input wire logic resetn,
	input wire logic ce,
	// Instruction stream from the core sequencer.
	input wire logic ins_valid,
	input wire slx_pkg::slx_instr_s ins,
	output var logic ins_ready,
	output var logic done,
	output var logic discarded,
	output var logic skip_next,
	// Register file port.
	output var logic [7:0] rf_addr,
	input wire logic [7:0] rf_rdata,
	output var logic rf_we,
	output var logic [7:0] rf_wdata,
	// Program memory port.
	output var logic [15:0] pm_addr,
	output var logic pm_rd,
	input wire logic [PM_W-1:0] pm_rdata,
	// Core state seen by the rest of the core.
	output var logic [7:0] working_register,
	output var logic zero_flag,
	output var logic [PM_W-9:0] lookup_result_high,
	// AXI4-Lite write address and data.
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output var logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output var logic s_axi_wready,
	// AXI4-Lite write response.
	output var logic [1:0] s_axi_bresp,
	output var logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read channels.
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output var logic s_axi_arready,
	output var logic [31:0] s_axi_rdata,
	output var logic [1:0] s_axi_rresp,
	output var logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// The high part must be at least one bit and the decode needs six bits.
	if (PM_W <= `SLX_BYTE_W || PM_W > 32 || ADDR_W < 6) begin : g_bad_param
		$error("slx_exec: unsupported PM_W or ADDR_W");
	end

	// Sequencer state and latched instruction.
	slx_pkg::slx_state_e state_q, state_d;
	slx_pkg::slx_instr_s instr_q, instr_d;
	// Handshake and pulse flops.
	logic ready_q, ready_d;
	logic done_q, done_d;
	logic disc_q, disc_d;
	logic skip_pend_q, skip_pend_d;
	// Register file and program memory drive.
	logic [7:0] rf_addr_q, rf_addr_d;
	logic rf_we_q, rf_we_d;
	logic [7:0] rf_wdata_q, rf_wdata_d;
	logic [15:0] pm_addr_q, pm_addr_d;
	logic pm_rd_q, pm_rd_d;
	// Architectural state shared with software.
	logic run_q, run_d;
	logic [7:0] work_q, work_d;
	logic zero_q, zero_d;
	logic [7:0] ptr_lo_q, ptr_lo_d;
	logic [7:0] ptr_hi_q, ptr_hi_d;
	logic [PM_W-9:0] res_hi_q, res_hi_d;
	// Bus channel state.
	logic aw_have_q, aw_have_d;
	logic w_have_q, w_have_d;
	logic [ADDR_W-1:0] awaddr_q, awaddr_d;
	logic [7:0] wbyte_q, wbyte_d;
	logic wlane_q, wlane_d;
	logic bvalid_q, bvalid_d;
	logic [1:0] bresp_q, bresp_d;
	logic rvalid_q, rvalid_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0] rresp_q, rresp_d;
	// A register write is applied in the cycle it fires.
	logic wr_fire;
	logic wr_hit;
	// Operation unit result for the latched instruction.
	slx_pkg::slx_alu_s alu;

	// The operation unit sees the register value read this cycle.
	slx_alu u_alu (
		.instr(instr_q),
		.operand(rf_rdata),
		.work(work_q),
		.result(alu)
	);

	// Decode the latched write address against the register map.
	always_comb begin
		wr_hit = (awaddr_q == ADDR_W'(`SLX_OFF_CTRL)) ||
			(awaddr_q == ADDR_W'(`SLX_OFF_WORK)) ||
			(awaddr_q == ADDR_W'(`SLX_OFF_FLAGS)) ||
			(awaddr_q == ADDR_W'(`SLX_OFF_PTR_LO)) ||
			(awaddr_q == ADDR_W'(`SLX_OFF_PTR_HI)) ||
			(awaddr_q == ADDR_W'(`SLX_OFF_RES_HI));
	end

	// Bus channel next state: address and data may come in either order.
	always_comb begin
		aw_have_d = aw_have_q;
		w_have_d = w_have_q;
		awaddr_d = awaddr_q;
		wbyte_d = wbyte_q;
		wlane_d = wlane_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		// Both halves are held until the previous response has gone.
		wr_fire = aw_have_q && w_have_q && !bvalid_q;
		if (s_axi_awvalid && !aw_have_q) begin
			aw_have_d = 1'b1;
			awaddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_have_q) begin
			w_have_d = 1'b1;
			wbyte_d = s_axi_wdata[7:0];
			wlane_d = s_axi_wstrb[0];
		end
		if (wr_fire) begin
			aw_have_d = 1'b0;
			w_have_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = wr_hit ? `SLX_RESP_OKAY : `SLX_RESP_SLVERR;
		end else if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		// Reads answer one cycle after the address is taken.
		if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end else if (s_axi_arvalid && !rvalid_q) begin
			rvalid_d = 1'b1;
			rresp_d = `SLX_RESP_OKAY;
			unique case (s_axi_araddr)
				ADDR_W'(`SLX_OFF_CTRL): rdata_d = 32'(run_q);
				ADDR_W'(`SLX_OFF_WORK): rdata_d = 32'(work_q);
				ADDR_W'(`SLX_OFF_FLAGS): begin
					rdata_d = '0;
					rdata_d[`SLX_FLAG_ZERO] = zero_q;
					rdata_d[`SLX_FLAG_SKIP] = skip_pend_q;
					rdata_d[`SLX_FLAG_BUSY] = (state_q != slx_pkg::ST_IDLE);
				end
				ADDR_W'(`SLX_OFF_PTR_LO): rdata_d = 32'(ptr_lo_q);
				ADDR_W'(`SLX_OFF_PTR_HI): rdata_d = 32'(ptr_hi_q);
				ADDR_W'(`SLX_OFF_RES_HI): rdata_d = 32'(res_hi_q);
				default: begin
					// Unmapped reads return zero with an error.
					rdata_d = '0;
					rresp_d = `SLX_RESP_SLVERR;
				end
			endcase
		end
	end

	// Bus channel registers.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= '0;
			wbyte_q <= `SLX_RST_BYTE;
			wlane_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= `SLX_RESP_OKAY;
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= `SLX_RESP_OKAY;
		end else if (ce) begin
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			awaddr_q <= awaddr_d;
			wbyte_q <= wbyte_d;
			wlane_q <= wlane_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

	// Core next state: software writes first, instruction results override.
	always_comb begin
		state_d = state_q;
		instr_d = instr_q;
		ready_d = ready_q;
		done_d = 1'b0;
		disc_d = 1'b0;
		skip_pend_d = skip_pend_q;
		rf_addr_d = rf_addr_q;
		rf_we_d = 1'b0;
		rf_wdata_d = rf_wdata_q;
		pm_addr_d = pm_addr_q;
		pm_rd_d = 1'b0;
		run_d = run_q;
		work_d = work_q;
		zero_d = zero_q;
		ptr_lo_d = ptr_lo_q;
		ptr_hi_d = ptr_hi_q;
		res_hi_d = res_hi_q;
		// Only the low byte lane carries register data.
		if (wr_fire && wlane_q) begin
			unique case (awaddr_q)
				ADDR_W'(`SLX_OFF_CTRL): run_d = wbyte_q[`SLX_CTRL_RUN];
				ADDR_W'(`SLX_OFF_WORK): work_d = wbyte_q;
				ADDR_W'(`SLX_OFF_FLAGS): zero_d = wbyte_q[`SLX_FLAG_ZERO];
				ADDR_W'(`SLX_OFF_PTR_LO): ptr_lo_d = wbyte_q;
				ADDR_W'(`SLX_OFF_PTR_HI): ptr_hi_d = wbyte_q;
				default: run_d = run_q;
			endcase
		end
		unique case (state_q)
			slx_pkg::ST_IDLE: begin
				if (ins_valid && ready_q) begin
					if (skip_pend_q) begin
						disc_d = 1'b1;
						done_d = 1'b1;
						skip_pend_d = 1'b0;
					end else begin
						instr_d = ins;
						rf_addr_d = ins.reg_addr;
						ready_d = 1'b0;
						state_d = slx_pkg::ST_EXEC;
					end
				end else begin
					// A stopped block refuses new instructions.
					ready_d = run_d;
				end
			end
			slx_pkg::ST_EXEC: begin
				if (instr_q.op inside {slx_pkg::OP_LOOKUP_TO_REGISTER,
						slx_pkg::OP_LOOKUP_TO_WORKING}) begin
					pm_addr_d = {ptr_hi_q, ptr_lo_q};
					pm_rd_d = 1'b1;
					state_d = slx_pkg::ST_FETCH;
				end else begin
					if (alu.wr_reg) begin
						rf_we_d = 1'b1;
						rf_wdata_d = alu.res;
					end
					if (alu.wr_work) begin
						work_d = alu.res;
					end
					if (alu.upd_zero) begin
						zero_d = alu.zero;
					end
					skip_pend_d = alu.skip;
					done_d = 1'b1;
					ready_d = run_d;
					state_d = slx_pkg::ST_IDLE;
				end
			end
			slx_pkg::ST_FETCH: begin
				if (instr_q.op == slx_pkg::OP_LOOKUP_TO_REGISTER) begin
					rf_we_d = 1'b1;
					rf_wdata_d = pm_rdata[7:0];
				end else begin
					work_d = pm_rdata[7:0];
				end
				res_hi_d = pm_rdata[PM_W-1:8];
				done_d = 1'b1;
				ready_d = run_d;
				state_d = slx_pkg::ST_IDLE;
			end
			default: state_d = slx_pkg::ST_IDLE;
		endcase
	end

	// Core registers; a low clock enable freezes everything.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_q <= slx_pkg::ST_IDLE;
			instr_q <= '0;
			ready_q <= 1'b0;
			done_q <= 1'b0;
			disc_q <= 1'b0;
			skip_pend_q <= 1'b0;
			rf_addr_q <= `SLX_RST_BYTE;
			rf_we_q <= 1'b0;
			rf_wdata_q <= `SLX_RST_BYTE;
			pm_addr_q <= '0;
			pm_rd_q <= 1'b0;
			run_q <= `SLX_RST_RUN;
			work_q <= `SLX_RST_BYTE;
			zero_q <= 1'b0;
			ptr_lo_q <= `SLX_RST_BYTE;
			ptr_hi_q <= `SLX_RST_BYTE;
			res_hi_q <= '0;
		end else if (ce) begin
			state_q <= state_d;
			instr_q <= instr_d;
			ready_q <= ready_d;
			done_q <= done_d;
			disc_q <= disc_d;
			skip_pend_q <= skip_pend_d;
			rf_addr_q <= rf_addr_d;
			rf_we_q <= rf_we_d;
			rf_wdata_q <= rf_wdata_d;
			pm_addr_q <= pm_addr_d;
			pm_rd_q <= pm_rd_d;
			run_q <= run_d;
			work_q <= work_d;
			zero_q <= zero_d;
			ptr_lo_q <= ptr_lo_d;
			ptr_hi_q <= ptr_hi_d;
			res_hi_q <= res_hi_d;
		end
	end

	// Every output is a flop, the three bus ready outputs through an inverter; the prot inputs carry no meaning here.
	assign ins_ready = ready_q;
	assign done = done_q;
	assign discarded = disc_q;
	assign skip_next = skip_pend_q;
	assign rf_addr = rf_addr_q;
	assign rf_we = rf_we_q;
	assign rf_wdata = rf_wdata_q;
	assign pm_addr = pm_addr_q;
	assign pm_rd = pm_rd_q;
	assign working_register = work_q;
	assign zero_flag = zero_q;
	assign lookup_result_high = res_hi_q;
	assign s_axi_awready = !aw_have_q;
	assign s_axi_wready = !w_have_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

endmodule // slx_exec
`default_nettype wire
